// file: rtl/cpuals_datapath.v
// 16-bit alu, status word, multiplier, divider and shifter of the cpu
// Operation
// RQ1 - half carry from bit 3 or bit 7
// RQ2 - three-bit priority level, 111 masks interrupts
// RQ3 - nesting disable makes priority level read-only
// RQ4 - priority extension bit, software may only clear
// RQ5 - repeat flag reads loop activity
// RQ6 - negative flag follows result sign
// RQ7 - overflow flag on signed overflow
// RQ8 - zero flag cleared only by non-zero result
// RQ9 - 16-bit two's complement alu, selective flags
// RQ10 - carry flags mean no borrow on subtract
// RQ11 - byte or word operations, any operand source
// RQ12 - multiplier with seven sign modes
// RQ13 - signed and unsigned 32/16 and 16/16 divide
// RQ14 - quotient to register zero, remainder register one
// RQ15 - divisor any register, dividend even pair
// RQ16 - one cycle per divisor bit
// RQ17 - barrel shift up to fifteen in one cycle
// RQ18 - multibit shifts register to register only
// RQ19 - arithmetic right, logical right, left shifts
// RQ20 - reserved control bit reads one, others zero
// RQ21 - full-width sign-correct products
`timescale 1ns/1ps
`include "cpuals_regs.vh"

module cpuals_datapath #(
	parameter DATA_WIDTH = 16
) (
	input wire clock,
	input wire reset,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire [31:0] prdata,
	output wire pslverr,
	// alu request from the decoder
	input wire alu_valid,
	input wire [3:0] alu_op,
	input wire byte_mode,
	input wire [15:0] operand_a,
	input wire [15:0] operand_b,
	input wire [3:0] shift_count,
	input wire shift_to_memory,
	input wire carry_in_use,
	output reg [15:0] alu_result,
	output reg alu_done,
	output reg alu_refused,
	// multiplier
	input wire mul_valid,
	input wire [2:0] mul_mode,
	input wire [15:0] mul_a,
	input wire [15:0] mul_b,
	input wire [4:0] mul_literal,
	output reg [31:0] mul_product,
	output reg mul_done,
	// divider; dividend pair and divisor read from the register file
	input wire div_start,
	input wire div_signed,
	input wire div_long,
	input wire [3:0] div_pair_index,
	input wire [3:0] div_divisor_index,
	output reg [3:0] reg_read_index_a,
	output reg [3:0] reg_read_index_b,
	output reg [3:0] reg_read_index_c,
	input wire [15:0] reg_read_a,
	input wire [15:0] reg_read_b,
	input wire [15:0] reg_read_c,
	output wire div_busy,
	output reg div_done,
	output reg [15:0] working_register_zero,
	output reg [15:0] working_register_one,
	// loop state from the sequencer
	input wire repeat_active,
	output wire [3:0] effective_priority
);

	reg [15:0] status;
	reg priority_level_extension;
	reg nesting_disable;
	wire [2:0] cpu_priority_level;
	assign cpu_priority_level = status[`CPUALS_SR_IPL_HI:`CPUALS_SR_IPL_LO];

	////////////////////////////////////////////////////////////////////
	// combinational alu
	reg [16:0] wide;
	reg [4:0] nib;
	reg [8:0] low_byte;
	reg [15:0] res;
	reg c_out, h_out, v_out, arith, logic_op;
	reg [15:0] a_eff, b_eff;
	wire [7:0] asr_byte = $signed(operand_a[7:0]) >>> shift_count;
	wire [15:0] asr_word = $signed(operand_a) >>> shift_count;
	always @* begin
		wide = 17'h00000;
		nib = 5'h00;
		low_byte = 9'h000;
		c_out = 1'b0;
		h_out = 1'b0;
		v_out = 1'b0;
		arith = 1'b0;
		logic_op = 1'b0;
		a_eff = byte_mode ? {8'h00, operand_a[7:0]} : operand_a; // RQ11
		b_eff = byte_mode ? {8'h00, operand_b[7:0]} : operand_b;
		res = 16'h0000;
		case (alu_op)
		`CPUALS_OP_ADD, `CPUALS_OP_SUB: begin
			arith = 1'b1;
			// subtract as a + ~b + 1, so carry means no borrow
			if (alu_op == `CPUALS_OP_SUB)
				b_eff = byte_mode ? {8'h00, ~operand_b[7:0]} : ~operand_b;
			wide = {1'b0, a_eff} + {1'b0, b_eff} +
				{16'h0000, alu_op == `CPUALS_OP_SUB}; // RQ10 RQ9
			nib = {1'b0, a_eff[3:0]} + {1'b0, b_eff[3:0]} +
				{4'h0, alu_op == `CPUALS_OP_SUB};
			low_byte = {1'b0, a_eff[7:0]} + {1'b0, b_eff[7:0]} +
				{8'h00, alu_op == `CPUALS_OP_SUB};
			res = byte_mode ? {8'h00, wide[7:0]} : wide[15:0];
			c_out = byte_mode ? low_byte[8] : wide[16];
			h_out = byte_mode ? nib[4] : low_byte[8]; // RQ1
			v_out = byte_mode ?
				(a_eff[7] == b_eff[7]) && (res[7] != a_eff[7]) :
				(a_eff[15] == b_eff[15]) && (res[15] != a_eff[15]); // RQ7
		end
		`CPUALS_OP_AND: begin
			res = a_eff & b_eff;
			logic_op = 1'b1;
		end
		`CPUALS_OP_OR: begin
			res = a_eff | b_eff;
			logic_op = 1'b1;
		end
		`CPUALS_OP_XOR: begin
			res = a_eff ^ b_eff;
			logic_op = 1'b1;
		end
		// single-cycle barrel shifts, 0..15 places
		`CPUALS_OP_ASR: begin
			res = byte_mode ? {8'h00, asr_byte} : asr_word; // RQ17 RQ19
			logic_op = 1'b1;
		end
		`CPUALS_OP_LSR: begin
			res = byte_mode ? {8'h00, operand_a[7:0] >> shift_count} :
				operand_a >> shift_count; // RQ19
			logic_op = 1'b1;
		end
		`CPUALS_OP_SL: begin
			res = byte_mode ? {8'h00, operand_a[7:0] << shift_count} :
				operand_a << shift_count; // RQ17 RQ19
			logic_op = 1'b1;
		end
		`CPUALS_OP_MOV: begin
			res = a_eff;
			logic_op = 1'b1;
		end
		default: res = 16'h0000;
		endcase
	end
	wire shift_op;
	assign shift_op = (alu_op == `CPUALS_OP_ASR) ||
		(alu_op == `CPUALS_OP_LSR) || (alu_op == `CPUALS_OP_SL);
	// a shift aimed at memory is refused, registers only
	wire alu_ok;
	assign alu_ok = alu_valid && !(shift_op && shift_to_memory); // RQ18
	wire res_neg;
	wire res_zero;
	assign res_neg = byte_mode ? res[7] : res[15];
	assign res_zero = byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
	// multi-word add with carry keeps a zero flag cleared
	wire next_zero;
	assign next_zero = carry_in_use ? (status[`CPUALS_SR_ZERO] & res_zero) :
		res_zero; // RQ8

	////////////////////////////////////////////////////////////////////
	// multiplier: operands widened to 17 bits by sign mode
	reg [16:0] m_a, m_b;
	always @* begin
		m_a = {1'b0, mul_a};
		m_b = {1'b0, mul_b};
		case (mul_mode)
		`CPUALS_MUL_SS: begin
			m_a = {mul_a[15], mul_a};
			m_b = {mul_b[15], mul_b};
		end
		`CPUALS_MUL_SU: m_a = {mul_a[15], mul_a};
		`CPUALS_MUL_US: m_b = {mul_b[15], mul_b};
		`CPUALS_MUL_SLIT: begin
			m_a = {mul_a[15], mul_a};
			m_b = {12'h000, mul_literal};
		end
		`CPUALS_MUL_ULIT: m_b = {12'h000, mul_literal};
		`CPUALS_MUL_BYTE: begin
			m_a = {9'h000, mul_a[7:0]};
			m_b = {9'h000, mul_b[7:0]};
		end
		default: m_a = {1'b0, mul_a};
		endcase
	end
	wire signed [33:0] m_full;
	assign m_full = $signed(m_a) * $signed(m_b); // RQ12
	wire [31:0] m_trim;
	assign m_trim = (mul_mode == `CPUALS_MUL_BYTE) ?
		{16'h0000, m_full[15:0]} : m_full[31:0]; // RQ21

	////////////////////////////////////////////////////////////////////
	// divider: restoring on magnitudes, 16 steps for both sizes
	localparam DIV_IDLE = 2'd0;
	localparam DIV_LOAD = 2'd1;
	localparam DIV_RUN = 2'd2;
	localparam DIV_DONE = 2'd3;
	reg [1:0] div_state;
	reg [4:0] div_count;
	reg [31:0] dvd_mag;
	reg [15:0] dsr_mag;
	reg [16:0] part_rem;
	reg [15:0] quo;
	reg neg_quo, neg_rem, is_signed, is_long;
	assign div_busy = (div_state != DIV_IDLE);
	// registers read: dividend low=even, high=odd, divisor any
	always @* begin
		reg_read_index_a = {div_pair_index[3:1], 1'b0}; // RQ15
		reg_read_index_b = {div_pair_index[3:1], 1'b1};
		reg_read_index_c = div_divisor_index;
	end
	wire [31:0] dvd_raw;
	assign dvd_raw = is_long ? {reg_read_b, reg_read_a} :
		(is_signed ? {{16{reg_read_a[15]}}, reg_read_a} :
		{16'h0000, reg_read_a}); // RQ13
	wire [31:0] dvd_neg = -dvd_raw;
	wire [16:0] trial;
	wire [17:0] shifted;
	assign shifted = {part_rem, dvd_mag[31]};
	assign trial = shifted[16:0] - {1'b0, dsr_mag};
	wire fits;
	assign fits = shifted >= {2'b00, dsr_mag};
	// the partial remainder starts with the high half preloaded so that
	// only 16 steps are needed; quotient must fit in 16 bits
	always @(posedge clock) begin
		if (reset) begin
			div_state <= DIV_IDLE;
			div_count <= 5'd0;
			dvd_mag <= 32'h00000000;
			dsr_mag <= 16'h0000;
			part_rem <= 17'h00000;
			quo <= 16'h0000;
			neg_quo <= 1'b0;
			neg_rem <= 1'b0;
			is_signed <= 1'b0;
			is_long <= 1'b0;
			div_done <= 1'b0;
			working_register_zero <= 16'h0000;
			working_register_one <= 16'h0000;
		end else begin
			div_done <= 1'b0;
			case (div_state)
			DIV_IDLE: if (div_start) begin
				is_signed <= div_signed;
				is_long <= div_long;
				div_state <= DIV_LOAD;
			end
			DIV_LOAD: begin
				neg_quo <= is_signed & (dvd_raw[31] ^ reg_read_c[15]);
				neg_rem <= is_signed & dvd_raw[31];
				dsr_mag <= (is_signed && reg_read_c[15]) ?
					-reg_read_c : reg_read_c;
				if (is_signed && dvd_raw[31]) begin
					dvd_mag <= {dvd_neg[15:0], 16'h0000};
					part_rem <= {1'b0, dvd_neg[31:16]};
				end else begin
					dvd_mag <= {dvd_raw[15:0], 16'h0000};
					part_rem <= {1'b0, dvd_raw[31:16]};
				end
				div_count <= `CPUALS_DIV_STEPS;
				div_state <= DIV_RUN;
			end
			DIV_RUN: begin
				part_rem <= fits ? trial : shifted[16:0];
				quo <= {quo[14:0], fits};
				dvd_mag <= {dvd_mag[30:0], 1'b0};
				div_count <= div_count - 5'd1; // RQ16
				if (div_count == 5'd1)
					div_state <= DIV_DONE;
			end
			DIV_DONE: begin
				working_register_zero <= neg_quo ? -quo : quo; // RQ14
				working_register_one <= neg_rem ?
					-part_rem[15:0] : part_rem[15:0]; // RQ14
				div_done <= 1'b1;
				div_state <= DIV_IDLE;
			end
			default: div_state <= DIV_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb decode; one-cycle access, pready always high
	wire wr_en;
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	wire [15:0] control_word;
	assign control_word = {12'h000, priority_level_extension, 1'b1,
		2'b00}; // RQ20
	reg [15:0] rd_mux;
	always @* begin
		case (paddr)
		`CPUALS_STATUS_ADDR: rd_mux = {status[15:5], repeat_active,
			status[3:0]}; // RQ5
		`CPUALS_CONTROL_ADDR: rd_mux = control_word;
		`CPUALS_INTCTL_ADDR: rd_mux = {nesting_disable, 15'h0000};
		`CPUALS_DIVRES_ADDR: rd_mux = working_register_zero;
		default: rd_mux = 16'h0000;
		endcase
	end
	assign prdata = {16'h0000, rd_mux};
	assign effective_priority = {priority_level_extension,
		cpu_priority_level}; // RQ2

	////////////////////////////////////////////////////////////////////
	// status word: alu flags win over a software write in the same cycle
	always @(posedge clock) begin
		if (reset) begin
			status <= `CPUALS_SR_RESET;
			priority_level_extension <= 1'b0;
			nesting_disable <= 1'b0;
			alu_result <= 16'h0000;
			alu_done <= 1'b0;
			alu_refused <= 1'b0;
			mul_product <= 32'h00000000;
			mul_done <= 1'b0;
		end else begin
			alu_done <= alu_ok;
			alu_refused <= alu_valid && !alu_ok;
			mul_done <= mul_valid;
			if (mul_valid)
				mul_product <= m_trim;
			if (wr_en && paddr == `CPUALS_STATUS_ADDR) begin
				status[`CPUALS_SR_HALF] <= pwdata[`CPUALS_SR_HALF];
				status[3:0] <= pwdata[3:0];
				if (!nesting_disable) // RQ3
					status[7:5] <= pwdata[7:5];
			end
			// extension bit: writing zero clears, one is ignored
			if (wr_en && paddr == `CPUALS_CONTROL_ADDR &&
				!pwdata[`CPUALS_CC_IPLX])
				priority_level_extension <= 1'b0; // RQ4
			if (wr_en && paddr == `CPUALS_INTCTL_ADDR)
				nesting_disable <= pwdata[`CPUALS_IC_NEST];
			if (alu_ok) begin
				alu_result <= res;
				status[`CPUALS_SR_NEG] <= res_neg; // RQ6
				status[`CPUALS_SR_ZERO] <= next_zero; // RQ8
				if (arith) begin
					status[`CPUALS_SR_CARRY] <= c_out; // RQ10
					status[`CPUALS_SR_HALF] <= h_out; // RQ1
					status[`CPUALS_SR_WRAP] <= v_out; // RQ7
				end
			end
			status[15:9] <= 7'h00;
			status[`CPUALS_SR_REPEAT] <= 1'b0;
		end
	end

endmodule // cpuals_datapath

// file: rtl/cpuals_regs.vh
// register offsets, field positions and reset values of the alu datapath
`ifndef CPUALS_REGS_VH
`define CPUALS_REGS_VH
// apb byte addresses (chosen)
`define CPUALS_STATUS_ADDR 12'h000
`define CPUALS_CONTROL_ADDR 12'h004
`define CPUALS_INTCTL_ADDR 12'h008
`define CPUALS_DIVRES_ADDR 12'h00c
// status word fields
`define CPUALS_SR_CARRY 0
`define CPUALS_SR_ZERO 1
`define CPUALS_SR_WRAP 2
`define CPUALS_SR_NEG 3
`define CPUALS_SR_REPEAT 4
`define CPUALS_SR_IPL_LO 5
`define CPUALS_SR_IPL_HI 7
`define CPUALS_SR_HALF 8
`define CPUALS_SR_RESET 16'h0000
// control word fields
`define CPUALS_CC_IPLX 3
`define CPUALS_CC_RSVD 2
`define CPUALS_IPL_MASKED 3'h7
// interrupt control one field
`define CPUALS_IC_NEST 15
// alu opcodes
`define CPUALS_OP_ADD 4'h0
`define CPUALS_OP_SUB 4'h1
`define CPUALS_OP_AND 4'h2
`define CPUALS_OP_OR 4'h3
`define CPUALS_OP_XOR 4'h4
`define CPUALS_OP_ASR 4'h5
`define CPUALS_OP_LSR 4'h6
`define CPUALS_OP_SL 4'h7
`define CPUALS_OP_MOV 4'h8
// multiply modes
`define CPUALS_MUL_SS 3'h0
`define CPUALS_MUL_UU 3'h1
`define CPUALS_MUL_SU 3'h2
`define CPUALS_MUL_US 3'h3
`define CPUALS_MUL_SLIT 3'h4
`define CPUALS_MUL_ULIT 3'h5
`define CPUALS_MUL_BYTE 3'h6
// divider iteration count, one per divisor bit
`define CPUALS_DIV_STEPS 5'd16
`endif

// file: verification/cpuals_datapath_monitor.sv
// port assertions of the alu datapath
`timescale 1ns/1ps
`include "cpuals_regs.vh"
module cpuals_datapath_monitor (
	input wire clock,
	input wire reset,
	input wire psel,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire alu_valid,
	input wire [3:0] alu_op,
	input wire byte_mode,
	input wire shift_to_memory,
	input wire [15:0] alu_result,
	input wire alu_done,
	input wire alu_refused,
	input wire mul_valid,
	input wire mul_done,
	input wire div_start,
	input wire div_busy,
	input wire div_done,
	input wire repeat_active,
	input wire [3:0] effective_priority
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////
	// decoded helpers, kept combinational
	wire rd_st = psel && paddr == `CPUALS_STATUS_ADDR;
	wire rd_cc = psel && paddr == `CPUALS_CONTROL_ADDR;
	wire is_sh = alu_op == `CPUALS_OP_ASR || alu_op == `CPUALS_OP_LSR ||
		alu_op == `CPUALS_OP_SL;
	// divide phases: accepted start, then a busy stretch
	sequence div_go;
		div_start && !div_busy;
	endsequence
	sequence div_run;
		div_busy [*8];
	endsequence
	////////////////////////////////////////////////////////////////////
	AST_ALU_DONE: assert property (alu_valid && !(is_sh && shift_to_memory)
		|=> alu_done) else $error("alu op not completed");
	AST_SHIFT_MEM: assert property (alu_valid && is_sh && shift_to_memory
		|=> alu_refused && $stable(alu_result)) else $error("shift to memory");
	AST_BYTE_UPPER: assert property (alu_done && $past(byte_mode)
		|-> alu_result[15:8] == 8'h00) else $error("byte upper not zero");
	AST_MUL_DONE: assert property (mul_valid |=> mul_done)
		else $error("product late");
	AST_DIV_TIME: assert property (div_go |=> div_run ##[10:11] div_done)
		else $error("divide length wrong");
	AST_REPEAT: assert property (rd_st |->
		prdata[`CPUALS_SR_REPEAT] == repeat_active) else $error("repeat bit");
	AST_PRIO: assert property (rd_st |->
		effective_priority[2:0] == prdata[7:5]) else $error("priority field");
	AST_CTRL: assert property (rd_cc |-> prdata[2] && prdata[1:0] == 2'h0
		&& prdata[31:4] == 28'h0) else $error("control word read");
endmodule // cpuals_datapath_monitor

// file: verification/cpuals_regfile_model.sv
// working register file model feeding the divider reads
`timescale 1ns/1ps
module cpuals_regfile_model (
	input wire [3:0] reg_read_index_a,
	input wire [3:0] reg_read_index_b,
	input wire [3:0] reg_read_index_c,
	output wire [15:0] reg_read_a,
	output wire [15:0] reg_read_b,
	output wire [15:0] reg_read_c
);
	logic [15:0] regs [0:15];
	// same-cycle reads, so load sees data without a wait state
	assign reg_read_a = regs[reg_read_index_a];
	assign reg_read_b = regs[reg_read_index_b];
	assign reg_read_c = regs[reg_read_index_c];
endmodule // cpuals_regfile_model

// file: verification/cpu_alu_status_datapath_test.sv
// self-checking bench of the alu datapath
`timescale 1ns/1ps
`include "cpuals_regs.vh"
module cpu_alu_status_datapath_test;
	logic clock, reset, psel, penable, pwrite, pready, pslverr;
	logic alu_valid, byte_mode, shift_to_memory, carry_in_use;
	logic alu_done, alu_refused, mul_valid, mul_done, div_start;
	logic div_signed, div_long, div_busy, div_done, repeat_active;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, mul_product, rd;
	logic [3:0] alu_op, shift_count, effective_priority;
	logic [3:0] reg_read_index_a, reg_read_index_b, reg_read_index_c;
	logic [3:0] div_pair_index, div_divisor_index;
	logic [15:0] operand_a, operand_b, alu_result, mul_a, mul_b;
	logic [15:0] reg_read_a, reg_read_b, reg_read_c;
	logic [15:0] working_register_zero, working_register_one;
	logic [2:0] mul_mode;
	logic [4:0] mul_literal;
	logic [3:0] top [0:5];
	logic [15:0] tres [0:5];
	int failures, comparisons, cycles, n1, n2;
	cpuals_datapath cpuals_datapath_i (.*);
	cpuals_regfile_model cpuals_regfile_model_i (.*);
	////////////////////////////////////////////////////////////////////
	// 200 mhz clock and a hang guard
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////////////
	task chk(input [31:0] s, input [31:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// apb cycle: setup, access held until pready at an edge
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	// one alu op; done and result are read after the taking edge
	task alu(input [3:0] op, input bm, ci, m, input [15:0] a, b,
		input [3:0] n);
		@(posedge clock);
		alu_valid <= 1;
		alu_op <= op;
		byte_mode <= bm;
		carry_in_use <= ci;
		shift_to_memory <= m;
		operand_a <= a;
		operand_b <= b;
		shift_count <= n;
		@(posedge clock);
		alu_valid <= 0;
		#1;
	endtask
	task mul(input [2:0] m, input [31:0] e);
		@(posedge clock);
		mul_valid <= 1;
		mul_mode <= m;
		@(posedge clock);
		mul_valid <= 0;
		#1 chk(mul_product, e);
	endtask
	task div(input s, l, input [3:0] p, v, input [31:0] e, output int n);
		@(posedge clock);
		div_start <= 1;
		div_signed <= s;
		div_long <= l;
		div_pair_index <= p;
		div_divisor_index <= v;
		@(posedge clock);
		div_start <= 0;
		n = 0;
		while (div_done !== 1'b1) begin
			@(posedge clock);
			n++;
		end
		chk({working_register_one, working_register_zero}, e);
	endtask
	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{psel, penable, pwrite, alu_valid, byte_mode, carry_in_use} = 0;
		{shift_to_memory, mul_valid, div_start, div_signed, div_long} = 0;
		{repeat_active, paddr, pwdata, alu_op, operand_a, operand_b} = 0;
		{shift_count, mul_mode, div_pair_index, div_divisor_index} = 0;
		{mul_a, mul_b, mul_literal} = {16'hffff, 16'hffff, 5'h1f};
		top = '{`CPUALS_OP_ASR, `CPUALS_OP_LSR, `CPUALS_OP_SL,
			`CPUALS_OP_AND, `CPUALS_OP_OR, `CPUALS_OP_XOR};
		tres = '{16'hf801, 16'h0801, 16'h0100, 16'h0010, 16'h8ff0, 16'h8fe0};
		reset = 1;
		repeat (6) @(posedge clock);
		reset <= 0;
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h0);
		apb(0, `CPUALS_CONTROL_ADDR, 0);
		chk(rd, 32'h4);
		apb(1, 12'h010, 32'hffff);
		apb(0, 12'h010, 0);
		chk(rd, 32'h0);
		chk(pslverr, 32'h0);
		$display("reset test done");
		alu(`CPUALS_OP_ADD, 1, 0, 0, 16'h000f, 16'h0001, 0);
		chk(alu_result, 16'h0010);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h0100);
		alu(`CPUALS_OP_ADD, 0, 0, 0, 16'h7fff, 16'h0001, 0);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h010c);
		alu(`CPUALS_OP_SUB, 0, 0, 0, 16'h0005, 16'h0005, 0);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h0103);
		alu(`CPUALS_OP_AND, 0, 1, 0, 16'h0000, 16'hffff, 0);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h0103);
		alu(`CPUALS_OP_AND, 0, 1, 0, 16'h00f0, 16'h0ff0, 0);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h0101);
		alu(`CPUALS_OP_ADD, 1, 0, 0, 16'h00ff, 16'h0001, 0);
		chk(alu_result, 16'h0000);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h0103);
		$display("flag test done");
		for (int i = 0; i < 6; i++) begin
			alu(top[i], 0, 0, 0, 16'h8010, 16'h0ff0, 4'h4);
			chk(alu_result, tres[i]);
		end
		alu(`CPUALS_OP_ASR, 0, 0, 0, 16'h8010, 0, 4'hf);
		chk(alu_result, 16'hffff);
		alu(`CPUALS_OP_SL, 0, 0, 1, 16'h1234, 0, 4'h1);
		chk({alu_refused, alu_result}, 17'h1ffff);
		$display("shift test done");
		mul(`CPUALS_MUL_SS, 32'h00000001);
		mul(`CPUALS_MUL_UU, 32'hfffe0001);
		mul(`CPUALS_MUL_SU, 32'hffff0001);
		mul(`CPUALS_MUL_US, 32'hffff0001);
		mul(`CPUALS_MUL_SLIT, 32'hffffffe1);
		mul(`CPUALS_MUL_ULIT, 32'h001effe1);
		mul(`CPUALS_MUL_BYTE, 32'h0000fe01);
		$display("multiply test done");
		cpuals_regfile_model_i.regs = '{16{16'h5a5a}};
		cpuals_regfile_model_i.regs[2] = 16'h0000;
		cpuals_regfile_model_i.regs[3] = 16'h0001;
		cpuals_regfile_model_i.regs[4] = 16'h0007;
		cpuals_regfile_model_i.regs[5] = 16'h0002;
		cpuals_regfile_model_i.regs[6] = 16'hfff9;
		div(0, 1, 4'h3, 4'h4, 32'h00022492, n1);
		div(1, 0, 4'h6, 4'h5, 32'hfffffffd, n2);
		chk(n1, n2);
		chk(n1, 19);
		$display("divide test done");
		apb(1, `CPUALS_STATUS_ADDR, 32'h00e0);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h00e0);
		chk(effective_priority, 4'h7);
		apb(1, `CPUALS_INTCTL_ADDR, 32'h8000);
		apb(1, `CPUALS_STATUS_ADDR, 0);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h00e0);
		apb(1, `CPUALS_INTCTL_ADDR, 0);
		apb(1, `CPUALS_STATUS_ADDR, 32'h0010);
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h0);
		@(posedge clock) repeat_active <= 1;
		apb(0, `CPUALS_STATUS_ADDR, 0);
		chk(rd, 32'h0010);
		apb(1, `CPUALS_CONTROL_ADDR, 32'hffff);
		apb(0, `CPUALS_CONTROL_ADDR, 0);
		chk(rd, 32'h4);
		chk(effective_priority, 4'h0);
		$display("priority test done");
		complete_run;
	end
endmodule // cpu_alu_status_datapath_test
bind cpuals_datapath cpuals_datapath_monitor cpuals_datapath_monitor_i (.*);
